/* logic/hpp_pkg.sv */
// constants for the host parallel port block
package hpp_pkg;
    localparam int HPP_DATA_W = 8;
    localparam logic [7:0] HPP_LATCH_RST = 8'h00;
    localparam logic [2:0] HPP_DIR_INPUTS = 3'h7;
    localparam int HPP_SYNC_STAGES = 2;
    localparam int HPP_STROBES = 3;
    localparam int HPP_CS_BIT = 2;
    localparam int HPP_RD_BIT = 1;
    localparam int HPP_WR_BIT = 0;
    localparam logic HPP_STROBE_IDLE = 1'b1;
    localparam logic HPP_FLAG_RST = 1'b0;
    typedef enum logic [1:0] {HPP_IDLE, HPP_WRITE, HPP_READ} hpp_state_t;
endpackage

/* logic/hpp_parallel_slave_port.sv */
// byte-wide slave port letting an external processor access the port latch
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - with mode enable set and all three control pins as inputs, the eight data pins act as a slave port.
// - reads and writes accepted anytime, driven only by the strobes.
// - external processor writes the host byte and reads the port latch, as whole bytes.
// - write runs from first select-and-write low until either seen high.
// - write end sets port access flag and input buffer full.
// - read start drives latch onto pins and sets output buffer full.
// - firmware write during read drives new byte out, leaves output full clear.
// - read end releases data pins and sets port access flag.
module hpp_parallel_slave_port
    import hpp_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic parallel_port_mode_enable_in,
    input wire logic [2:0] control_pin_direction_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] data_pin_in,
    output logic [7:0] data_pin_out,
    output logic data_pin_oe_out,
    input wire logic latch_wr_in,
    input wire logic [7:0] latch_wdata_in,
    output logic [7:0] byte_port_latch_out,
    input wire logic latch_rd_in,
    output logic [7:0] host_byte_out,
    input wire logic port_access_flag_clr_in,
    input wire logic output_buffer_full_clr_in,
    output logic input_buffer_full_out,
    output logic output_buffer_full_out,
    output logic port_access_flag_out
);

    ////////////////////////////////////////////////////////////////////////////
    // true when chip select and the given strobe are both low
    function automatic logic pair_low(input logic sel_n, input logic strb_n);
        return !sel_n && !strb_n;
    endfunction

    // raw strobes in one vector: chip select, read, write
    wire [HPP_STROBES-1:0] strobe_raw_n;
    wire [HPP_STROBES-1:0] strobe_sync_n;
    logic [7:0] wr_data_r;

    assign strobe_raw_n[HPP_CS_BIT] = cs_n_in;
    assign strobe_raw_n[HPP_RD_BIT] = rd_n_in;
    assign strobe_raw_n[HPP_WR_BIT] = wr_n_in;

    // one chain per strobe; stage one feeds nothing but stage two
    // strobes reset to their idle high level so no false edge follows reset
    for (genvar i = 0; i < HPP_STROBES; i++) begin : g_sync
        logic [HPP_SYNC_STAGES-1:0] chain_r;

        always_ff @(posedge ref_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                chain_r <= {HPP_SYNC_STAGES{HPP_STROBE_IDLE}};
            end else begin
                chain_r <= {chain_r[HPP_SYNC_STAGES-2:0], strobe_raw_n[i]};
            end
        end

        assign strobe_sync_n[i] = chain_r[HPP_SYNC_STAGES-1];
    end

    // data sampled every cycle the raw strobes say write; last one before release wins
    // raw pins used so the byte is caught while write is still low; the
    // trade is that the host must hold data steady up to the last clock edge before release
    wire raw_wr_low = pair_low(cs_n_in, wr_n_in);

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wr_data_r <= HPP_LATCH_RST;
        end else if (raw_wr_low) begin
            wr_data_r <= data_pin_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // decoded strobe levels; port only works with mode on and pins as inputs
    wire port_on = parallel_port_mode_enable_in
                   && (control_pin_direction_in == HPP_DIR_INPUTS);
    wire cs_sync_n = strobe_sync_n[HPP_CS_BIT];
    wire rd_sync_n = strobe_sync_n[HPP_RD_BIT];
    wire wr_sync_n = strobe_sync_n[HPP_WR_BIT];
    wire wr_act = port_on && pair_low(cs_sync_n, wr_sync_n);
    wire rd_act = port_on && pair_low(cs_sync_n, rd_sync_n);

    hpp_state_t state_r;
    hpp_state_t state_nxt;

    // write has priority if both strobes low; host must not do that
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            HPP_IDLE: begin
                if (wr_act) begin
                    state_nxt = HPP_WRITE;
                end else if (rd_act) begin
                    state_nxt = HPP_READ;
                end
            end
            HPP_WRITE: begin
                if (!wr_act) begin
                    state_nxt = HPP_IDLE;
                end
            end
            HPP_READ: begin
                if (!rd_act) begin
                    state_nxt = HPP_IDLE;
                end
            end
            default: state_nxt = HPP_IDLE;
        endcase
    end

    wire wr_end = (state_r == HPP_WRITE) && (state_nxt == HPP_IDLE);
    wire rd_start = (state_r == HPP_IDLE) && (state_nxt == HPP_READ);
    wire rd_end = (state_r == HPP_READ) && (state_nxt == HPP_IDLE);
    wire in_read = (state_r == HPP_READ);

    ////////////////////////////////////////////////////////////////////////////
    // latch and flags; hardware set wins over a same-cycle clear
    logic [7:0] latch_r;
    logic [7:0] host_byte_r;
    logic in_full_r;
    logic out_full_r;
    logic paf_r;
    logic oe_r;

    // flag set and clear terms
    wire in_full_set = wr_end;
    wire in_full_clr = latch_rd_in;
    // firmware reload on the read's first edge keeps output full from setting
    wire out_full_set = rd_start && !latch_wr_in;
    // a reload later in the read takes the flag back down
    wire out_full_clr = output_buffer_full_clr_in || (in_read && latch_wr_in);
    wire paf_set = wr_end || rd_end;
    wire paf_clr = port_access_flag_clr_in;

    // state register
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= HPP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // port latch, written by firmware only
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            latch_r <= HPP_LATCH_RST;
        end else if (latch_wr_in) begin
            latch_r <= latch_wdata_in;
        end
    end

    // byte from the host, moved over only once the write has ended
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_byte_r <= HPP_LATCH_RST;
        end else if (wr_end) begin
            host_byte_r <= wr_data_r;
        end
    end

    // input buffer full; firmware read of the byte clears it
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            in_full_r <= HPP_FLAG_RST;
        end else if (in_full_set) begin
            in_full_r <= 1'b1;
        end else if (in_full_clr) begin
            in_full_r <= 1'b0;
        end
    end

    // output buffer full
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            out_full_r <= HPP_FLAG_RST;
        end else if (out_full_set) begin
            out_full_r <= 1'b1;
        end else if (out_full_clr) begin
            out_full_r <= 1'b0;
        end
    end

    // port access flag, raised at the end of either kind of access
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            paf_r <= HPP_FLAG_RST;
        end else if (paf_set) begin
            paf_r <= 1'b1;
        end else if (paf_clr) begin
            paf_r <= 1'b0;
        end
    end

    // pin drive follows the next state so it starts and stops with the read
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            oe_r <= HPP_FLAG_RST;
        end else begin
            oe_r <= (state_nxt == HPP_READ);
        end
    end

    // pins show the live latch so a mid-read update goes straight out
    assign data_pin_out = latch_r;
    assign data_pin_oe_out = oe_r;
    assign byte_port_latch_out = latch_r;
    assign host_byte_out = host_byte_r;
    assign input_buffer_full_out = in_full_r;
    assign output_buffer_full_out = out_full_r;
    assign port_access_flag_out = paf_r;

endmodule

`default_nettype wire

/* dv/hpp_checker.sv */
// assertions on the host parallel port pins
`timescale 1ns/10ps
`default_nettype none
module hpp_checker (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic cs_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic latch_wr_in,
    input wire logic [7:0] latch_wdata_in,
    input wire logic data_pin_oe_out,
    input wire logic input_buffer_full_out,
    input wire logic output_buffer_full_out,
    input wire logic port_access_flag_out,
    input wire logic [7:0] data_pin_out,
    input wire logic [7:0] host_byte_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    sync_lag_a: assert property (!data_pin_oe_out && $fell(rd_n_in) |->
        !data_pin_oe_out [*2]) else $error("early drive");
    read_start_a: assert property ($rose(data_pin_oe_out) |->
        !$past(cs_n_in, 2) && !$past(rd_n_in, 2)) else $error("stray drive");
    read_end_a: assert property ($fell(data_pin_oe_out) |->
        port_access_flag_out) else $error("no read flag");
    write_end_a: assert property ($rose(input_buffer_full_out) |->
        port_access_flag_out) else $error("no write flag");
    flag_cause_a: assert property ($rose(port_access_flag_out) |->
        $past(cs_n_in, 2) || $past(rd_n_in, 2) && $past(wr_n_in, 2)) else $error("stray flag");
    full_read_a: assert property ($rose(output_buffer_full_out) |->
        $rose(data_pin_oe_out)) else $error("stray full");
    latch_out_a: assert property (data_pin_oe_out && latch_wr_in |=>
        data_pin_out == $past(latch_wdata_in)) else $error("old byte on pins");
    full_hold_a: assert property (data_pin_oe_out && latch_wr_in |=>
        !output_buffer_full_out) else $error("full after reload");
    full_suppress_a: assert property ($rose(data_pin_oe_out) && $past(latch_wr_in) |->
        !output_buffer_full_out) else $error("full on reload start");
    host_byte_a: assert property ($changed(host_byte_out) |->
        input_buffer_full_out) else $error("stray byte");
    cover property ($rose(input_buffer_full_out));
    cover property ($fell(data_pin_oe_out));
    cover property ($rose(data_pin_oe_out) && !output_buffer_full_out);
    cover property (data_pin_oe_out && latch_wr_in);
endmodule
bind hpp_parallel_slave_port hpp_checker u_hpp_checker (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .cs_n_in(cs_n_in),
    .rd_n_in(rd_n_in),
    .wr_n_in(wr_n_in),
    .latch_wr_in(latch_wr_in),
    .latch_wdata_in(latch_wdata_in),
    .data_pin_oe_out(data_pin_oe_out),
    .input_buffer_full_out(input_buffer_full_out),
    .output_buffer_full_out(output_buffer_full_out),
    .port_access_flag_out(port_access_flag_out),
    .data_pin_out(data_pin_out),
    .host_byte_out(host_byte_out)
);
`default_nettype wire

/* dv/hpp_host_model.sv */
// external processor model driving strobes and data
`timescale 1ns/10ps
`default_nettype none
module hpp_host_model (
    input wire logic clk_in,
    input wire logic oe_in,
    input wire logic [7:0] bus_in,
    output logic cs_n_out = 1'b1,
    output logic rd_n_out = 1'b1,
    output logic wr_n_out = 1'b1,
    output logic [7:0] d_out = 8'h00
);
    logic [7:0] q_r;
    // released data flips so a stale byte cannot pass
    task automatic xfer(input logic wr, input logic [7:0] d, input int len);
        @(negedge clk_in) {cs_n_out, rd_n_out, wr_n_out, d_out} = {1'b0, wr, !wr, d};
        repeat (len) @(negedge clk_in);
        {q_r, cs_n_out, rd_n_out, wr_n_out, d_out} = {oe_in ? bus_in : 8'hxx, 3'h7, ~d};
        repeat (4) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

/* dv/hpp_parallel_slave_port_test.sv */
// bench for the host parallel port
`timescale 1ns/10ps
`default_nettype none
module hpp_parallel_slave_port_test;
    import hpp_pkg::*;
    logic ref_clk_in = 0, nrst_in = 0, parallel_port_mode_enable_in = 1, cs_n_in, rd_n_in, wr_n_in;
    logic data_pin_oe_out, input_buffer_full_out, output_buffer_full_out, port_access_flag_out;
    logic [2:0] control_pin_direction_in = HPP_DIR_INPUTS;
    logic [3:0] fw_r = 4'h0;
    logic [7:0] data_pin_in, data_pin_out, latch_wdata_in = 8'h00, byte_port_latch_out;
    logic [7:0] host_byte_out;
    int miscompares = 0, cmp_count = 0;
    hpp_parallel_slave_port u_hpp_parallel_slave_port (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .parallel_port_mode_enable_in(parallel_port_mode_enable_in),
        .control_pin_direction_in(control_pin_direction_in),
        .cs_n_in(cs_n_in),
        .rd_n_in(rd_n_in),
        .wr_n_in(wr_n_in),
        .data_pin_in(data_pin_in),
        .data_pin_out(data_pin_out),
        .data_pin_oe_out(data_pin_oe_out),
        .latch_wr_in(fw_r[3]),
        .latch_wdata_in(latch_wdata_in),
        .byte_port_latch_out(byte_port_latch_out),
        .latch_rd_in(fw_r[2]),
        .host_byte_out(host_byte_out),
        .port_access_flag_clr_in(fw_r[1]),
        .output_buffer_full_clr_in(fw_r[0]),
        .input_buffer_full_out(input_buffer_full_out),
        .output_buffer_full_out(output_buffer_full_out),
        .port_access_flag_out(port_access_flag_out)
    );
    hpp_host_model u_hpp_host_model(.clk_in(ref_clk_in), .oe_in(data_pin_oe_out),
        .bus_in(data_pin_out), .cs_n_out(cs_n_in), .rd_n_out(rd_n_in), .wr_n_out(wr_n_in),
        .d_out(data_pin_in));
    initial forever #10 ref_clk_in = ~ref_clk_in;
    task chk(input logic [9:0] s, e);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %0t got %h not %h", $time, s, e);
        end
    endtask
    // firmware pulse: latch write, latch read, flag clear, full clear
    task fw(input logic [3:0] p, input logic [7:0] d);
        @(negedge ref_clk_in) {fw_r, latch_wdata_in} = {p, d};
        @(negedge ref_clk_in) fw_r = 4'h0;
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog, far beyond the roughly ninety cycles needed
    initial begin
        #60000 miscompares++;
        print_verdict();
    end
    initial begin
        repeat (10) @(negedge ref_clk_in);
        nrst_in = 1;
        u_hpp_host_model.xfer(1, 8'ha5, 4);
        chk({input_buffer_full_out, port_access_flag_out, host_byte_out}, 10'h3a5);
        fw(4'h6, 8'h00);
        chk({input_buffer_full_out, port_access_flag_out}, 10'h000);
        fw(4'h8, 8'h3c);
        u_hpp_host_model.xfer(0, 8'h00, 6);
        chk({output_buffer_full_out, port_access_flag_out, u_hpp_host_model.q_r}, 10'h33c);
        chk({1'b0, data_pin_oe_out, byte_port_latch_out}, 10'h03c);
        // latch reloaded on the edge the read is seen, then one edge later:
        // new byte out either way and no full flag left behind
        for (int i = 0; i < 2; i++) begin
            logic [7:0] new_byte;
            new_byte = i ? 8'hc3 : 8'h5a;
            fw(4'h3, 8'h00);
            fork
                u_hpp_host_model.xfer(0, 8'h00, 6);
                begin
                    repeat (2 + i) @(negedge ref_clk_in);
                    fw(4'h8, new_byte);
                end
            join
            chk({output_buffer_full_out, port_access_flag_out}, 10'h001);
            chk({2'b00, u_hpp_host_model.q_r}, {2'b00, new_byte});
        end
        // port off, then a wrong pin direction: writes must be ignored
        for (int i = 0; i < 2; i++) begin
            {parallel_port_mode_enable_in, control_pin_direction_in} = i ? 4'he : 4'h7;
            u_hpp_host_model.xfer(1, 8'h11, 4);
            chk({input_buffer_full_out, host_byte_out}, 10'h0a5);
        end
        // mid-run reset: flags and bytes back to zero, then a fresh write works
        @(negedge ref_clk_in) nrst_in = 0;
        repeat (2) @(negedge ref_clk_in);
        nrst_in = 1;
        chk({input_buffer_full_out, port_access_flag_out, host_byte_out}, 10'h000);
        chk({output_buffer_full_out, data_pin_oe_out, byte_port_latch_out}, 10'h000);
        {parallel_port_mode_enable_in, control_pin_direction_in} = 4'hf;
        u_hpp_host_model.xfer(1, 8'h96, 4);
        chk({input_buffer_full_out, port_access_flag_out, host_byte_out}, 10'h396);
        print_verdict();
    end
endmodule
`default_nettype wire
